// File: rtl/usb_host_register_map.v
// Behaviour
// RQ1 - Control, frame and root-hub registers are 32-bit operational registers.
// RQ2 - Operational register read code equals its standard offset divided by four.
// RQ3 - Driver must not assume reserved fields read as zero.
// RQ4 - Driver modifies read-write registers by read, alter wanted bits, write back.
// RQ5 - Driver may keep a shadow copy instead of reading before writing.
// RQ6 - Driver writes zeros into reserved bits of set or clear registers.
// RQ7 - Control group decoded at read 00 to 05, write 81 to 85.
// RQ8 - Frame interval 0D/8D, slow cutoff 11/91; 0E and 0F read only.
// RQ9 - Root-hub registers decoded at 12/92 through 16/96, all 32 bits.
// RQ10 - DMA and interrupt registers decoded at 20/A0 to 25/A5, 16 bits; the code leaves 23/A3 undecoded.
// RQ11 - Buffer lengths 2A/AA, 2B/AB, ports 40/C0, 41/C1; 2C-2E read only.
// RQ12 - Version register read only; low byte is version, upper bits zero.
// RQ13 - Write code is read code plus bit 7; 27, 28/A8, A9 decoded.
// RQ14 - Writes to registers without a write code are ignored.
`timescale 1ns/100ps
`default_nettype none
`include "usb_host_regs_defines.vh"
module usb_host_register_map #(
   parameter [7:0]  VERSION_CODE = 8'h01,   // Arbitrary value
   parameter [15:0] PART_ID_CODE = 16'h0123 // Arbitrary value
) (
   // Clock and reset
   input  wire        sys_clk,
   input  wire        reset_n,
   // Command and data port
   input  wire        cmdStrobe,
   input  wire [7:0]  cmdCode,
   input  wire        dataWrStrobe,
   input  wire [15:0] wrData,
   input  wire        dataRdStrobe,
   output reg  [15:0] rdData,
   output reg         rdValid,
   // Live state from the controller
   input  wire [31:0] frameTimeLeft,
   input  wire [31:0] frameCount,
   input  wire [15:0] bufferState,
   input  wire [15:0] bank0Length,
   input  wire [15:0] bank1Length,
   input  wire [15:0] bufPortRdData,
   // Control towards the controller
   output reg  [31:0] operatingMode,
   output reg  [15:0] hardwareSetup,
   output reg         softRestart,
   // Buffer port streams
   output reg         bufPortWrStrobe,
   output reg         bufPortRdStrobe,
   output reg         bufPortAsync,
   output reg  [15:0] bufPortWrData
);

   // Reset release
   reg        rstMeta;
   reg        rstSync;

   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rstMeta <= 1'b0;
         rstSync <= 1'b0;
      end else begin
         rstMeta <= 1'b1;
         rstSync <= rstMeta;
      end
   end

   // Storage slot of a register kept in the memory
   function [4:0] slotOf;
      input [6:0] idx;
      begin
         case (idx)
            `IDX_COMMAND:        slotOf = 5'h00;
            `IDX_EVENT_FLAGS:    slotOf = 5'h01;
            `IDX_EVENT_EN_SET:   slotOf = 5'h02;
            `IDX_EVENT_EN_CLR:   slotOf = 5'h03;
            `IDX_FRAME_INTERVAL: slotOf = 5'h04;
            `IDX_SLOW_CUTOFF:    slotOf = 5'h05;
            `IDX_HUB_DESC_A:     slotOf = 5'h06;
            `IDX_HUB_DESC_B:     slotOf = 5'h07;
            `IDX_HUB_STATE:      slotOf = 5'h08;
            `IDX_PORT_ONE:       slotOf = 5'h09;
            `IDX_PORT_TWO:       slotOf = 5'h0A;
            `IDX_DMA_SETUP:      slotOf = 5'h0B;
            `IDX_XFER_COUNT:     slotOf = 5'h0C;
            `IDX_CPU_EVENT:      slotOf = 5'h0D;
            `IDX_CPU_EVENT_EN:   slotOf = 5'h0E;
            `IDX_SPARE:          slotOf = 5'h0F;
            `IDX_PERIODIC_LEN:   slotOf = 5'h10;
            `IDX_ASYNC_LEN:      slotOf = 5'h10 + 5'h00 + 5'h01;
            default:             slotOf = `SLOT_NONE;
         endcase
      end
   endfunction

   // Registers that own a write code
   function hasWrite;
      input [6:0] idx;
      begin
         case (idx)
            `IDX_MODE,
            `IDX_HW_SETUP,
            `IDX_SOFT_RESTART,
            `IDX_PERIODIC_PORT,
            `IDX_ASYNC_PORT: hasWrite = 1'b1;
            default:         hasWrite = (slotOf(idx) != `SLOT_NONE);
         endcase
      end
   endfunction

   // Registers that own a read code
   function hasRead;
      input [6:0] idx;
      begin
         case (idx)
            `IDX_VERSION,
            `IDX_MODE,
            `IDX_FRAME_LEFT,
            `IDX_FRAME_COUNT,
            `IDX_HW_SETUP,
            `IDX_PART_ID,
            `IDX_BUFFER_STATE,
            `IDX_BANK0_LEN,
            `IDX_BANK1_LEN,
            `IDX_PERIODIC_PORT,
            `IDX_ASYNC_PORT: hasRead = 1'b1;
            default:         hasRead = (slotOf(idx) != `SLOT_NONE);
         endcase
      end
   endfunction

   // Current command
   reg        curWrite;
   reg [6:0]  curIdx;
   reg        curValid;
   reg [1:0]  phase;
   reg [15:0] lowHold;
   reg [`SLOT_COUNT-1:0] slotWritten;

   // Index below 20h selects a two-word register
   wire       curWide = (curIdx < `CMD_WIDE_LIMIT);                       // RQ1
   wire [4:0] curSlot = slotOf(curIdx);
   wire       isPort  = (curIdx == `IDX_PERIODIC_PORT) || (curIdx == `IDX_ASYNC_PORT);

   always @(posedge sys_clk or negedge rstSync) begin
      if (!rstSync) begin
         curWrite <= 1'b0;
         curIdx   <= `IDX_VERSION;
         curValid <= 1'b0;
      end else if (cmdStrobe) begin
         curWrite <= cmdCode[`CMD_WRITE_BIT];                              // RQ13
         curIdx   <= cmdCode[`CMD_INDEX_MSB:0];                            // RQ2
         curValid <= cmdCode[`CMD_WRITE_BIT] ? hasWrite(cmdCode[`CMD_INDEX_MSB:0])
                                             : hasRead(cmdCode[`CMD_INDEX_MSB:0]);
      end
   end

   // Write path
   reg        next_commit;
   reg [31:0] next_word;
   // Data strobes coinciding with a command are dropped
   wire       wrTaken = dataWrStrobe && curWrite && curValid && !cmdStrobe; // RQ14

   always @* begin
      next_commit = 1'b0;
      next_word   = {`HALF_ZERO, wrData};
      if (wrTaken && !isPort && (phase != `PHASE_DONE)) begin
         // Wide low half waits in lowHold; only its high half commits, a narrow word commits at once
         if (!curWide) begin
            next_commit = 1'b1;                                            // RQ10
         end else if (phase == `PHASE_HIGH) begin
            next_commit = 1'b1;                                            // RQ9
            next_word   = {wrData, lowHold};
         end
      end
   end

   // Registers without a slot live in flip-flops instead
   wire memWrite = next_commit && (curSlot != `SLOT_NONE);

   always @(posedge sys_clk or negedge rstSync) begin
      if (!rstSync) begin
         phase           <= `PHASE_LOW;
         lowHold         <= `HALF_ZERO;
         slotWritten     <= {`SLOT_COUNT{1'b0}};
         operatingMode   <= `MODE_RESET;
         hardwareSetup   <= `HW_SETUP_RESET;
         softRestart     <= 1'b0;
         bufPortWrStrobe <= 1'b0;
         bufPortAsync    <= 1'b0;
         bufPortWrData   <= `HALF_ZERO;
      end else begin
         softRestart     <= 1'b0;
         bufPortWrStrobe <= 1'b0;
         // A new command abandons any half-finished word pair
         if (cmdStrobe) begin
            phase <= `PHASE_LOW;
         end else if (wrTaken && !isPort && (phase != `PHASE_DONE)) begin
            if (curWide && (phase == `PHASE_LOW)) begin
               lowHold <= wrData;
               phase   <= `PHASE_HIGH;
            end else begin
               phase <= `PHASE_DONE;
            end
         end else if (dataRdStrobe && !curWrite && curValid && !isPort) begin
            if (curWide && (phase == `PHASE_LOW)) begin
               phase <= `PHASE_HIGH;
            end else begin
               phase <= `PHASE_DONE;
            end
         end
         if (memWrite) begin
            slotWritten[curSlot] <= 1'b1;
         end
         if (next_commit && (curIdx == `IDX_MODE)) begin
            operatingMode <= next_word;                                     // RQ7
         end
         if (next_commit && (curIdx == `IDX_HW_SETUP)) begin
            hardwareSetup <= next_word[15:0];                               // RQ10
         end
         if (next_commit && (curIdx == `IDX_SOFT_RESTART)) begin
            softRestart <= 1'b1;                                            // RQ13
         end
         if (wrTaken && isPort) begin
            bufPortWrStrobe <= 1'b1;                                        // RQ11
            bufPortAsync    <= (curIdx == `IDX_ASYNC_PORT);
            bufPortWrData   <= wrData;
         end
      end
   end

   // Stored registers
   wire [31:0] memQ;

   // Read and write share the slot address; data lags one cycle
   reg_store #(
      .WIDTH     (32),
      .ADDR_BITS (5)
   ) u_store (
      .sys_clk     (sys_clk),
      .writeEnable (memWrite),
      .writeAddr   (curSlot),
      .writeData   (next_word),
      .readAddr    (curSlot),
      .readData    (memQ)
   );

   // Read selection
   reg [31:0] readWord;

   always @* begin
      readWord = 32'h00000000;
      case (curIdx)
         `IDX_VERSION:      readWord = {`VERSION_RSVD, VERSION_CODE};       // RQ12
         `IDX_MODE:         readWord = operatingMode;                       // RQ7
         `IDX_FRAME_LEFT:   readWord = frameTimeLeft;                       // RQ8
         `IDX_FRAME_COUNT:  readWord = frameCount;                          // RQ8
         `IDX_HW_SETUP:     readWord = {`HALF_ZERO, hardwareSetup};         // RQ10
         `IDX_PART_ID:      readWord = {`HALF_ZERO, PART_ID_CODE};          // RQ13
         `IDX_BUFFER_STATE: readWord = {`HALF_ZERO, bufferState};           // RQ11
         `IDX_BANK0_LEN:    readWord = {`HALF_ZERO, bank0Length};           // RQ11
         `IDX_BANK1_LEN:    readWord = {`HALF_ZERO, bank1Length};           // RQ11
         `IDX_PERIODIC_PORT,
         `IDX_ASYNC_PORT:   readWord = {`HALF_ZERO, bufPortRdData};         // RQ11
         default: begin
            // Unwritten slots read zero, not power-up memory contents
            if ((curSlot != `SLOT_NONE) && slotWritten[curSlot]) begin
               readWord = memQ;                                             // RQ9
            end
         end
      endcase
   end

   // Read path
   wire rdTaken = dataRdStrobe && !curWrite && !cmdStrobe;

   always @(posedge sys_clk or negedge rstSync) begin
      if (!rstSync) begin
         rdData          <= `HALF_ZERO;
         rdValid         <= 1'b0;
         bufPortRdStrobe <= 1'b0;
      end else begin
         rdValid         <= 1'b0;
         bufPortRdStrobe <= 1'b0;
         if (rdTaken) begin
            rdValid <= 1'b1;
            // Words past the end of a register read as zero
            if (!curValid || (phase == `PHASE_DONE)) begin
               rdData <= `HALF_ZERO;
            end else if (curWide && (phase == `PHASE_HIGH)) begin
               rdData <= readWord[31:16];                                   // RQ1
            end else begin
               rdData <= readWord[15:0];
            end
            if (curValid && isPort) begin
               // Async flag follows port writes only
               bufPortRdStrobe <= 1'b1;                                     // RQ11
            end
         end
      end
   end

endmodule
`default_nettype wire

// File: rtl/usb_host_regs_defines.vh
`ifndef USB_HOST_REGS_DEFINES_VH
`define USB_HOST_REGS_DEFINES_VH

// Command code layout
`define CMD_WRITE_BIT      7
`define CMD_INDEX_MSB      6
`define CMD_WIDE_LIMIT     7'h20

// Register indices (read codes)
`define IDX_VERSION        7'h00
`define IDX_MODE           7'h01
`define IDX_COMMAND        7'h02
`define IDX_EVENT_FLAGS    7'h03
`define IDX_EVENT_EN_SET   7'h04
`define IDX_EVENT_EN_CLR   7'h05
`define IDX_FRAME_INTERVAL 7'h0D
`define IDX_FRAME_LEFT     7'h0E
`define IDX_FRAME_COUNT    7'h0F
`define IDX_SLOW_CUTOFF    7'h11
`define IDX_HUB_DESC_A     7'h12
`define IDX_HUB_DESC_B     7'h13
`define IDX_HUB_STATE      7'h14
`define IDX_PORT_ONE       7'h15
`define IDX_PORT_TWO       7'h16
`define IDX_HW_SETUP       7'h20
`define IDX_DMA_SETUP      7'h21
`define IDX_XFER_COUNT     7'h22
`define IDX_CPU_EVENT      7'h24
`define IDX_CPU_EVENT_EN   7'h25
`define IDX_PART_ID        7'h27
`define IDX_SPARE          7'h28
`define IDX_SOFT_RESTART   7'h29
`define IDX_PERIODIC_LEN   7'h2A
`define IDX_ASYNC_LEN      7'h2B
`define IDX_BUFFER_STATE   7'h2C
`define IDX_BANK0_LEN      7'h2D
`define IDX_BANK1_LEN      7'h2E
`define IDX_PERIODIC_PORT  7'h40
`define IDX_ASYNC_PORT     7'h41

// Storage slots
`define SLOT_NONE          5'h1F
`define SLOT_COUNT         18

// Word phase of a transfer
`define PHASE_LOW          2'h0
`define PHASE_HIGH         2'h1
`define PHASE_DONE         2'h2

// Reset values
`define MODE_RESET         32'h00000000
`define HW_SETUP_RESET     16'h0000
`define VERSION_RSVD       24'h000000
`define HALF_ZERO          16'h0000

`endif

// File: rtl/reg_store.v
`timescale 1ns/100ps
`default_nettype none
module reg_store #(
   parameter WIDTH     = 32,
   parameter ADDR_BITS = 5
) (
   // Clock
   input  wire                 sys_clk,
   // Write side
   input  wire                 writeEnable,
   input  wire [ADDR_BITS-1:0] writeAddr,
   input  wire [WIDTH-1:0]     writeData,
   // Read side
   input  wire [ADDR_BITS-1:0] readAddr,
   output reg  [WIDTH-1:0]     readData
);

   reg [WIDTH-1:0] cells [0:(1<<ADDR_BITS)-1];

   always @(posedge sys_clk) begin
      if (writeEnable) begin
         cells[writeAddr] <= writeData;
      end
      readData <= cells[readAddr];
   end

endmodule
`default_nettype wire

// File: bench/usb_host_register_map_props.sv
`timescale 1ns/100ps
`default_nettype none
module usb_host_register_map_props (
   // Clock and reset
   input wire logic        sys_clk,
   input wire logic        reset_n,
   // Command and data port
   input wire logic        cmdStrobe,
   input wire logic        dataWrStrobe,
   input wire logic        dataRdStrobe,
   input wire logic [15:0] wrData,
   input wire logic        rdValid,
   // Outputs under watch
   input wire logic [31:0] operatingMode,
   input wire logic [15:0] hardwareSetup,
   input wire logic        softRestart,
   input wire logic        bufPortWrStrobe,
   input wire logic        bufPortRdStrobe,
   input wire logic [15:0] bufPortWrData
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   sequence s_word_req;
      dataRdStrobe && !cmdStrobe;
   endsequence
   sequence s_word_in;
      $past(dataWrStrobe) && bufPortWrData == $past(wrData);
   endsequence
   property p_rd_answer;
      s_word_req |=> rdValid;
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read word not answered");
   property p_rd_cause;
      rdValid |-> $past(dataRdStrobe);
   endproperty
   a_rd_cause: assert property (p_rd_cause) else $error("read answer without request");
   property p_mode_cause;
      !$stable(operatingMode) |-> $past(dataWrStrobe);
   endproperty
   a_mode_cause: assert property (p_mode_cause) else $error("mode changed without word");
   property p_mode_high;
      !$stable(operatingMode) |-> operatingMode[31:16] == $past(wrData);
   endproperty
   a_mode_high: assert property (p_mode_high) else $error("mode not committed on high");
   property p_setup_word;
      !$stable(hardwareSetup) |-> hardwareSetup == $past(wrData);
   endproperty
   a_setup_word: assert property (p_setup_word) else $error("setup word mismatch");
   property p_restart_pulse;
      softRestart |-> $past(dataWrStrobe) ##1 !softRestart;
   endproperty
   a_restart_pulse: assert property (p_restart_pulse) else $error("restart pulse wrong");
   property p_port_word;
      bufPortWrStrobe |-> s_word_in;
   endproperty
   a_port_word: assert property (p_port_word) else $error("port word wrong");
   property p_port_read;
      bufPortRdStrobe |-> $past(dataRdStrobe);
   endproperty
   a_port_read: assert property (p_port_read) else $error("port read without request");
endmodule
bind usb_host_register_map usb_host_register_map_props u_props (.sys_clk, .reset_n, .cmdStrobe,
   .dataWrStrobe, .dataRdStrobe, .wrData, .rdValid, .operatingMode, .hardwareSetup,
   .softRestart, .bufPortWrStrobe, .bufPortRdStrobe, .bufPortWrData);
`default_nettype wire

// File: bench/usb_host_register_map_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; \
   $display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end
module usb_host_register_map_tb_top;
   localparam [7:0]  VER = 8'h25;    // Arbitrary value
   localparam [15:0] PID = 16'h5A3C; // Arbitrary value
   localparam [31:0] LIVE = 32'h00FF00FF; // Assumed in-use bits of the set/clear pair
   logic        sys_clk, reset_n, cmdStrobe, dataWrStrobe, dataRdStrobe;
   logic [7:0]  cmdCode;
   logic [15:0] wrData, bufPortRdData, bufferState, bank0Length, bank1Length, e;
   logic [31:0] frameTimeLeft, frameCount, operatingMode, seed, v;
   logic [15:0] rdData, hardwareSetup, bufPortWrData;
   logic        rdValid, softRestart, bufPortWrStrobe, bufPortRdStrobe, bufPortAsync;
   logic [15:0] expQ[$];
   logic [6:0]  wideIdx [0:11] = '{7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h0D, 7'h11, 7'h12,
                                   7'h13, 7'h14, 7'h15, 7'h16};
   logic [6:0]  narrowIdx [0:7] = '{7'h20, 7'h21, 7'h22, 7'h24, 7'h25, 7'h28, 7'h2A, 7'h2B};
   logic [6:0]  roIdx [0:6] = '{7'h00, 7'h0E, 7'h0F, 7'h27, 7'h2C, 7'h2D, 7'h2E};
   logic [31:0] roVal [0:6];
   int          failures, checked, i;
   usb_host_register_map #(.VERSION_CODE(VER), .PART_ID_CODE(PID)) dut (.sys_clk, .reset_n,
      .cmdStrobe, .cmdCode, .dataWrStrobe, .wrData, .dataRdStrobe, .rdData, .rdValid,
      .frameTimeLeft, .frameCount, .bufferState, .bank0Length, .bank1Length, .bufPortRdData,
      .operatingMode, .hardwareSetup, .softRestart, .bufPortWrStrobe, .bufPortRdStrobe,
      .bufPortAsync, .bufPortWrData);
   always #10 sys_clk = ~sys_clk;
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic tick;
      @(posedge sys_clk);
      #1;
   endtask
   task automatic cmd(input logic [7:0] c);
      cmdStrobe = 1'b1;
      cmdCode = c;
      tick;
      cmdStrobe = 1'b0;
   endtask
   // Strobe stays up between back-to-back words
   task automatic wr(input logic [15:0] w, input logic more);
      dataWrStrobe = 1'b1;
      wrData = w;
      tick;
      if (!more) dataWrStrobe = 1'b0;
   endtask
   task automatic rd(input logic [15:0] x, input logic more);
      expQ.push_back(x);
      dataRdStrobe = 1'b1;
      tick;
      if (!more) dataRdStrobe = 1'b0;
   endtask
   // Gap before command keeps reads clear of a fresh commit
   task automatic rdReg(input logic [6:0] idx, input logic [31:0] x, input logic wide);
      tick;
      cmd({1'b0, idx});
      tick;
      rd(x[15:0], wide);
      if (wide) rd(x[31:16], 1'b0);
   endtask
   task automatic wrReg(input logic [6:0] idx, input logic [31:0] w, input logic wide);
      cmd({1'b1, idx});
      wr(w[15:0], wide);
      if (wide) wr(w[31:16], 1'b0);
   endtask
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      if (rdValid === 1'b1) begin
         `CHK(expQ.size() != 0, 1'b1)
         if (expQ.size() != 0) begin
            e = expQ.pop_front();
            `CHK(rdData, e)
         end
      end
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      failures++;
      conclude;
   end
   initial begin
      {sys_clk, reset_n, cmdStrobe, dataWrStrobe, dataRdStrobe} = 5'h00;
      cmdCode = 8'h00;
      wrData = 16'h0000;
      seed = 32'd33911;
      frameTimeLeft = rnd();
      frameCount = rnd();
      v = rnd();
      bufferState = v[15:0];
      bank0Length = v[31:16];
      bank1Length = frameCount[15:0] ^ 16'hA5A5;
      bufPortRdData = 16'h0000;
      roVal = '{{24'h0, VER}, frameTimeLeft, frameCount, {16'h0, PID}, {16'h0, bufferState},
                {16'h0, bank0Length}, {16'h0, bank1Length}};
      repeat (6) @(posedge sys_clk);
      #1;
      reset_n = 1'b1;
      repeat (3) tick;
      for (i = 0; i < 7; i++) begin
         rdReg(roIdx[i], roVal[i], roIdx[i] < 7'h20);
         wrReg(roIdx[i], ~roVal[i], roIdx[i] < 7'h20);
         rdReg(roIdx[i], roVal[i], roIdx[i] < 7'h20);
      end
      v = rnd();
      wrReg(7'h01, v, 1'b1);
      tick;
      `CHK(operatingMode, v)
      cmd(8'h81);
      wr(~v[15:0], 1'b0);
      tick;
      `CHK(operatingMode, v)
      for (i = 0; i < 12; i++) begin
         v = rnd();
         wrReg(wideIdx[i], v, 1'b1);
         rdReg(wideIdx[i], v, 1'b1);
      end
      for (i = 0; i < 8; i++) begin
         v = rnd();
         wrReg(narrowIdx[i], v, 1'b0);
         tick;
         if (i == 0) `CHK(hardwareSetup, v[15:0])
         rdReg(narrowIdx[i], {16'h0, v[15:0]}, 1'b0);
      end
      v = rnd();
      wrReg(7'h02, v, 1'b1);
      rdReg(7'h02, v, 1'b1);
      v[3:0] = ~v[3:0];
      wrReg(7'h02, v, 1'b1);
      rdReg(7'h02, v, 1'b1);
      v[7:4] = ~v[7:4];
      wrReg(7'h01, v, 1'b1);
      tick;
      `CHK(operatingMode, v)
      wrReg(7'h04, v & LIVE, 1'b1);
      rdReg(7'h04, v & LIVE, 1'b1);
      rdReg(7'h29, 32'h0, 1'b0);
      cmd(8'hA9);
      v = rnd();
      wr(v[15:0], 1'b0);
      `CHK(softRestart, 1'b1)
      tick;
      `CHK(softRestart, 1'b0)
      for (i = 0; i < 2; i++) begin
         cmd(8'hC0 | i[7:0]);
         v = rnd();
         wr(v[15:0], 1'b1);
         `CHK(bufPortWrStrobe, 1'b1)
         `CHK(bufPortWrData, v[15:0])
         `CHK(bufPortAsync, i[0])
         wr(v[31:16], 1'b0);
         `CHK(bufPortWrData, v[31:16])
         cmd(8'h40 | i[7:0]);
         bufPortRdData = v[15:0] ^ 16'h3C3C;
         tick;
         rd(bufPortRdData, 1'b0);
         `CHK(bufPortRdStrobe, 1'b1)
      end
      tick;
      reset_n = 1'b0;
      tick;
      reset_n = 1'b1;
      repeat (3) tick;
      `CHK(operatingMode, 32'h00000000)
      rdReg(7'h01, 32'h0, 1'b1);
      repeat (4) tick;
      `CHK(expQ.size(), 0)
      conclude;
   end
endmodule
`default_nettype wire
